// [pin_remap_consts.svh]
`ifndef PIN_REMAP_CONSTS_SVH
`define PIN_REMAP_CONSTS_SVH
// ****************************************
// Register map
// ****************************************
`define SEL_REG_COUNT 10
`define SEL_BASE_ADDR 8'h00
`define SEL_ADDR_LAST 8'h24
`define FIRST_PIN 40
`define PIN_COUNT 20
// ****************************************
// Field layout
// ****************************************
`define ODD_FIELD_LSB 8
`define EVEN_FIELD_LSB 0
`define FIELD_W 6
`define SEL_RESET 6'h00
`define FUNC_COUNT 64
`define FUNC_NONE 6'h00
`define WRITE_MASK 16'h3F3F
`endif

// [pin_remap_pkg.sv]
package pin_remap_pkg;
    typedef logic [5:0] func_sel_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRESP = 2'b01,
        BUS_RDATA = 2'b10
    } bus_state_t;
endpackage

// [pin_select_reg.sv]
`timescale 1ns/1ns
`include "pin_remap_consts.svh"
module pin_select_reg
    import pin_remap_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Write port
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_strb,
    // Fields
    output func_sel_t even_sel,
    output func_sel_t odd_sel
);
    func_sel_t next_even_sel;
    func_sel_t next_odd_sel;

    always_comb begin
        next_even_sel = even_sel;
        next_odd_sel = odd_sel;
        if (wr_en && wr_strb[0]) begin
            next_even_sel = wr_data[`EVEN_FIELD_LSB +: `FIELD_W];
        end
        if (wr_en && wr_strb[1]) begin
            next_odd_sel = wr_data[`ODD_FIELD_LSB +: `FIELD_W];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            even_sel <= `SEL_RESET;
            odd_sel <= `SEL_RESET;
        end else begin
            even_sel <= next_even_sel;
            odd_sel <= next_odd_sel;
        end
    end
endmodule

// [pin_output_mux.sv]
`timescale 1ns/1ns
`include "pin_remap_consts.svh"
module pin_output_mux
    import pin_remap_pkg::*;
(
    // Selection
    input wire func_sel_t sel,
    // Sources
    input wire logic [63:0] func_out,
    input wire logic port_out,
    // Pad
    output logic pad_out,
    output logic remapped
);
    always_comb begin
        remapped = (sel != `FUNC_NONE) && func_valid(sel);
        pad_out = remapped ? func_out[sel] : port_out;
    end

    function automatic logic func_valid(input func_sel_t s);
        return int'(s) < `FUNC_COUNT;
    endfunction
endmodule

// [output_pin_remap_select.sv]
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "pin_remap_consts.svh"
module output_pin_remap_select
    import pin_remap_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Peripheral functions and port latches
    input wire logic [63:0] func_out,
    input wire logic [19:0] port_out,
    // Pads
    output logic [19:0] pad_out,
    output logic [19:0] pad_remapped
);
    // ****************************************
    // Write channel
    // ****************************************
    logic aw_held;
    logic w_held;
    wr_req_t wreq;
    logic next_aw_held;
    logic next_w_held;
    wr_req_t next_wreq;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic do_write;
    logic [3:0] wr_idx;
    func_sel_t even_sel [`SEL_REG_COUNT];
    func_sel_t odd_sel [`SEL_REG_COUNT];

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= `SEL_ADDR_LAST);
    endfunction

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_wreq = wreq;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (awvalid && awready) begin
            next_aw_held = 1'b1;
            next_wreq.addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_held = 1'b1;
            next_wreq.data = wdata;
            next_wreq.strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        do_write = aw_held && w_held;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_ok(wreq.addr) ? 2'b00 : 2'b10;
        end
        wr_idx = wreq.addr[5:2];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wreq <= '0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            wreq <= next_wreq;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
        end
    end

    // ****************************************
    // Selection registers and pad muxes
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `SEL_REG_COUNT; g++) begin : g_reg
            pin_select_reg u_reg (
                .clk_sys(clk_sys),
                .rst(rst),
                .wr_en(do_write && addr_ok(wreq.addr) && (wr_idx == 4'(g))),
                .wr_data(wreq.data[15:0]),
                .wr_strb(wreq.strb[1:0]),
                .even_sel(even_sel[g]),
                .odd_sel(odd_sel[g])
            );
            pin_output_mux u_even (
                .sel(even_sel[g]),
                .func_out(func_out),
                .port_out(port_out[2*g]),
                .pad_out(pad_out[2*g]),
                .remapped(pad_remapped[2*g])
            );
            pin_output_mux u_odd (
                .sel(odd_sel[g]),
                .func_out(func_out),
                .port_out(port_out[2*g+1]),
                .pad_out(pad_out[2*g+1]),
                .remapped(pad_remapped[2*g+1])
            );
        end
    endgenerate

    // ****************************************
    // Read channel
    // ****************************************
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [3:0] rd_idx;

    assign arready = !rvalid;

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        rd_idx = araddr[5:2];
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata = 32'h00000000;
            next_rresp = 2'b10;
            if (addr_ok(araddr)) begin
                next_rresp = 2'b00;
                next_rdata = {16'h0000, 2'b00, odd_sel[rd_idx], 2'b00, even_sel[rd_idx]};
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'b00;
        end else begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    write_takes_a: assert property (@(posedge clk_sys) disable iff (rst)
        (do_write && addr_ok(wreq.addr) && wreq.strb[0] && wr_idx == 4'd0)
        |=> (even_sel[0] == $past(wreq.data[5:0])))
        else $error("even field not written");
    odd_takes_a: assert property (@(posedge clk_sys) disable iff (rst)
        (do_write && addr_ok(wreq.addr) && wreq.strb[1] && wr_idx == 4'd9)
        |=> (odd_sel[9] == $past(wreq.data[13:8])))
        else $error("odd field not written");
    read_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
        rvalid |-> (rdata[15:14] == 2'b00))
        else $error("high unimplemented bits nonzero");
    read_mid_a: assert property (@(posedge clk_sys) disable iff (rst)
        rvalid |-> (rdata[7:6] == 2'b00))
        else $error("middle unimplemented bits nonzero");
    read_even_a: assert property (@(posedge clk_sys) disable iff (rst)
        (arvalid && arready && araddr == 8'h00) |=> (rdata[5:0] == $past(even_sel[0])))
        else $error("even field readback wrong");
    pad_route_a: assert property (@(posedge clk_sys) disable iff (rst)
        (even_sel[0] != 6'h00) |-> (pad_out[0] == func_out[even_sel[0]]))
        else $error("pad not driven by selected function");
    pad_port_a: assert property (@(posedge clk_sys) disable iff (rst)
        (odd_sel[0] == 6'h00) |-> (pad_out[1] == port_out[1] && !pad_remapped[1]))
        else $error("unselected pad not port pin");
    resp_after_a: assert property (@(posedge clk_sys) disable iff (rst)
        do_write |=> bvalid)
        else $error("write response missing");

    write_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        do_write |=> (!aw_held && !w_held))
        else $error("write request not released");
    aw_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
        (aw_held && !w_held && !(wvalid && wready)) |=> aw_held)
        else $error("write address dropped early");
    w_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
        (w_held && !aw_held && !(awvalid && awready)) |=> w_held)
        else $error("write data dropped early");
    bresp_ok_a: assert property (@(posedge clk_sys) disable iff (rst)
        (do_write && addr_ok(wreq.addr)) |=> (bresp == 2'b00))
        else $error("mapped write not answered okay");
    bad_write_a: assert property (@(posedge clk_sys) disable iff (rst)
        (do_write && !addr_ok(wreq.addr)) |=> (bresp == 2'b10))
        else $error("bad write address not refused");
    bresp_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (bvalid && !bready) |=> (bvalid && $stable(bresp)))
        else $error("write response dropped early");
    resp_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (bvalid && bready) |=> !bvalid)
        else $error("write response not cleared");

    read_answer_a: assert property (@(posedge clk_sys) disable iff (rst)
        (arvalid && arready) |=> rvalid)
        else $error("read answer missing");
    rresp_ok_a: assert property (@(posedge clk_sys) disable iff (rst)
        (arvalid && arready && addr_ok(araddr)) |=> (rresp == 2'b00))
        else $error("mapped read not answered okay");
    bad_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        (arvalid && arready && !addr_ok(araddr))
        |=> (rresp == 2'b10 && rdata == 32'h00000000))
        else $error("bad read address not refused");
    rdata_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
        else $error("read data dropped early");
    rvalid_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        (rvalid && rready) |=> !rvalid)
        else $error("read data not cleared");
    read_upper_a: assert property (@(posedge clk_sys) disable iff (rst)
        rvalid |-> (rdata[31:16] == 16'h0000))
        else $error("upper read half nonzero");

    // ****************************************
    // Per-register checks
    // ****************************************
    generate
        for (g = 0; g < `SEL_REG_COUNT; g++) begin : g_chk
            // Each register and the two pads that it steers
            even_write_a: assert property (@(posedge clk_sys) disable iff (rst)
                (do_write && addr_ok(wreq.addr) && wreq.strb[0] && wr_idx == 4'(g))
                |=> (even_sel[g] == $past(wreq.data[5:0])))
                else $error("even field write lost");

            odd_write_a: assert property (@(posedge clk_sys) disable iff (rst)
                (do_write && addr_ok(wreq.addr) && wreq.strb[1] && wr_idx == 4'(g))
                |=> (odd_sel[g] == $past(wreq.data[13:8])))
                else $error("odd field write lost");

            even_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
                !(do_write && addr_ok(wreq.addr) && wreq.strb[0] && wr_idx == 4'(g))
                |=> $stable(even_sel[g]))
                else $error("even field changed without a write");

            odd_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
                !(do_write && addr_ok(wreq.addr) && wreq.strb[1] && wr_idx == 4'(g))
                |=> $stable(odd_sel[g]))
                else $error("odd field changed without a write");

            readback_a: assert property (@(posedge clk_sys) disable iff (rst)
                (arvalid && arready && araddr == {2'b00, 4'(g), 2'b00})
                |=> (rdata[13:0] == {$past(odd_sel[g]), 2'b00, $past(even_sel[g])}))
                else $error("field readback wrong");

            even_route_a: assert property (@(posedge clk_sys) disable iff (rst)
                (even_sel[g] != 6'h00)
                |-> (pad_out[2*g] == func_out[even_sel[g]] && pad_remapped[2*g]))
                else $error("even pad not driven by its function");

            odd_route_a: assert property (@(posedge clk_sys) disable iff (rst)
                (odd_sel[g] != 6'h00)
                |-> (pad_out[2*g+1] == func_out[odd_sel[g]] && pad_remapped[2*g+1]))
                else $error("odd pad not driven by its function");

            even_port_a: assert property (@(posedge clk_sys) disable iff (rst)
                (even_sel[g] == 6'h00)
                |-> (pad_out[2*g] == port_out[2*g] && !pad_remapped[2*g]))
                else $error("idle even pad not a port pin");

            odd_port_a: assert property (@(posedge clk_sys) disable iff (rst)
                (odd_sel[g] == 6'h00)
                |-> (pad_out[2*g+1] == port_out[2*g+1] && !pad_remapped[2*g+1]))
                else $error("idle odd pad not a port pin");

            reset_clear_a: assert property (@(posedge clk_sys)
                $fell(rst) |-> (even_sel[g] == 6'h00 && odd_sel[g] == 6'h00))
                else $error("field not cleared by reset");
        end
    endgenerate
endmodule

// [periph_source.sv]
`timescale 1ns/1ns
module periph_source (
    // Pattern select
    input wire logic flip,
    // Peripheral outputs and port latches
    output logic [63:0] func_out,
    output logic [19:0] port_out
);
    // Every source flips together, so a stale pad value is caught
    assign func_out = flip ? 64'h5A3CF069C3A51E78 : 64'hA5C30F963C5AE187;
    assign port_out = flip ? 20'hA5C3C : 20'h5A3C3;
endmodule

// [tb.sv]
`timescale 1ns/1ns
module tb;
    import pin_remap_pkg::*;
    typedef struct packed {
        logic [3:0] idx;
        logic [31:0] d;
        logic [3:0] s;
        logic [31:0] e;
    } row_t;
    logic clk_sys = 0, rst = 1, flip = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v;
    logic [63:0] fo;
    logic [19:0] po, pad_out, pad_remapped;
    int n_mismatch = 0, check_count = 0;
    row_t rows [5] = '{
        '{4'h0, 32'hFFFFFFFF, 4'hF, 32'h00003F3F},
        '{4'h9, 32'h00002A00, 4'h3, 32'h00002A00},
        '{4'h4, 32'hFFFF2705, 4'h2, 32'h00002700},
        '{4'h4, 32'h0000C0C5, 4'h1, 32'h00002705},
        '{4'h5, 32'h12343F3F, 4'hC, 32'h00000000}};
    always #25 clk_sys = ~clk_sys;
    periph_source src_u (.flip(flip), .func_out(fo), .port_out(po));
    output_pin_remap_select dut_u (.clk_sys(clk_sys), .rst(rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .func_out(fo), .port_out(po),
        .pad_out(pad_out), .pad_remapped(pad_remapped));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_sys);
        awvalid <= 1;
        awaddr <= a;
        wvalid <= 1;
        wdata <= d;
        wstrb <= s;
        bready <= 1;
        do begin
            @(posedge clk_sys);
            if (awvalid && awready === 1'b1) awvalid <= 0;
            if (wvalid && wready === 1'b1) wvalid <= 0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        do begin
            @(posedge clk_sys);
            if (arvalid && arready === 1'b1) arvalid <= 0;
        end while (rvalid !== 1'b1);
        v = rdata;
        r = rresp;
        rready <= 0;
    endtask
    task automatic pads(input int k, input logic [31:0] e);
        logic [5:0] sel;
        int p;
        for (int j = 0; j < 2; j++) begin
            sel = j ? e[13:8] : e[5:0];
            p = 2 * k + j;
            chk("pad_out", pad_out[p], sel == 0 ? po[p] : fo[sel]);
            chk("pad_remapped", pad_remapped[p], sel != 0);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        for (int i = 0; i < 5; i++) begin
            wr({rows[i].idx, 2'b00}, rows[i].d, rows[i].s);
            chk("bresp", r, 2'b00);
            rd({rows[i].idx, 2'b00});
            chk("rdata", v, rows[i].e);
            flip <= ~flip;
            @(posedge clk_sys);
            pads(rows[i].idx, rows[i].e);
        end
        for (int k = 1; k < 4; k++) begin
            rd(8'(4 * k));
            chk("reset value", v, 0);
            pads(k, 0);
        end
        wr(8'h28, 32'h00003F3F, 4'hF);
        chk("bad addr bresp", r, 2'b10);
        rd(8'h28);
        chk("bad addr rresp", r, 2'b10);
        chk("bad addr rdata", v, 0);
        wr(8'h05, 32'h00003F3F, 4'hF);
        chk("unaligned bresp", r, 2'b10);
        rd(8'h04);
        chk("unaligned no write", v, 0);
        rd(8'h06);
        chk("unaligned rresp", r, 2'b10);
        rd(8'h00);
        chk("no stray write", v, 32'h00003F3F);
        rst <= 1;
        @(posedge clk_sys);
        chk("reset remapped", pad_remapped, 0);
        chk("reset port pins", pad_out, po);
        rst <= 0;
        rd(8'h24);
        chk("mid-run reset", v, 0);
        pads(9, 0);
        finish_test();
    end
endmodule
